// file: include/cvn_cfg.svh
// constants for the node configuration and status block
`ifndef CVN_CFG_SVH
`define CVN_CFG_SVH
// ****************************************************************
// object dictionary and addressing
// ****************************************************************
`define CVN_IDX_NODE_ADDR   16'h2100
`define CVN_IDX_VALVE_STAT  16'h2102
`define CVN_SUB_ZERO        8'h00
`define CVN_ADDR_MIN        8'h01
`define CVN_ADDR_MAX        8'h7F
`define CVN_SW_ADDR_MAX     8'h63
`define CVN_ADDR_DEFAULT    7'h7F
`define CVN_BCD_MAX         4'h9
`define CVN_VALVE_ON        8'h01
`define CVN_VALVE_OFF       8'h00
// ****************************************************************
// layer setting service command specifiers (decimal as printed)
// ****************************************************************
`define CVN_COB_LSS         11'h7E5
`define CVN_LSS_SWITCH      8'h04
`define CVN_LSS_NODE_ID     8'h11
`define CVN_LSS_BIT_SEL     8'h13
`define CVN_LSS_BIT_ACT     8'h15
`define CVN_LSS_STORE       8'h17
// ****************************************************************
// indicator timing
// ****************************************************************
`define CVN_CLK_MHZ         100
`define CVN_TICK_MS         50
`define CVN_FLASH_TICKS     6'h08
`define CVN_FRAME_LAST      6'h2F
`define CVN_INIT_LAST       2'h3
`endif

// file: include/cvn_pkg.sv
// types for the node configuration and status block
package cvn_pkg;
   typedef enum logic [1:0] {
      CVN_NMT_INIT,
      CVN_NMT_PREOP,
      CVN_NMT_OPER,
      CVN_NMT_STOP
   } cvn_nmt_t;

   typedef struct packed {
      logic        wr;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [7:0]  wdata;
   } cvn_obj_req_t;

   typedef struct packed {
      logic       ack;
      logic       err;
      logic [7:0] rdata;
   } cvn_obj_rsp_t;

   typedef struct packed {
      logic [7:0] cs;
      logic [7:0] b1;
      logic [7:0] b2;
   } cvn_lss_req_t;

   typedef struct packed {
      logic warn;
      logic bus_off;
      logic hb_evt;
      logic guard_evt;
      logic sync_evt;
      logic clr;
   } cvn_can_evt_t;

   typedef struct packed {
      logic        err;
      logic        green;
      logic        red;
   } cvn_led_t;

   typedef struct packed {
      logic [7:0]  bt_sel;
      logic [7:0]  bt_idx;
      logic        bt_act;
      logic [15:0] bt_delay;
   } cvn_bt_t;
endpackage : cvn_pkg

// file: rtl/cvn_node_cfg.sv
// node address selection, object access, lss decode and indicator drive
// Behaviour
// - address from two decimal selectors 1..99; software addresses up to 127
// - selector changes only take effect after a power reset
// - both selectors zero: use the software-assigned address
// - with no other assignment, node address is 127
// - write to 2100h sub 0 stores address to nv memory, 1..127 only
// - decode lss commands 04, 17, 19, 21, 23 on the lss identifier
// - read 2102h sub 0 gives 01h with valve supply, 00h without
// - error indicator shows bus condition and missing sync/guard/heartbeat
// - run led: blink preop, flash stopped, on operational, off in init; error led off when no fault is flagged, except power-up flash and baud/lss flicker
// - baud detection active: flicker error and run green indicators
// - address change in commissioning: flicker error and run green
// - error frames: single flash; bus off: steady; run shows state
// - heartbeat event double flash; missing sync triple flash
`include "cvn_cfg.svh"
module cvn_node_cfg
   import cvn_pkg::*;
#(
   parameter int P_TICK_CYC = `CVN_TICK_MS * 1000 * `CVN_CLK_MHZ
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_arst_n,
   input  wire logic [3:0]    i_sel_tens,
   input  wire logic [3:0]    i_sel_ones,
   input  wire logic          i_valve_supply,
   input  wire logic [7:0]    i_nv_addr,
   input  wire logic          i_obj_req,
   input  wire cvn_obj_req_t  i_obj,
   input  wire logic          i_lss_valid,
   input  wire logic [10:0]   i_lss_cob,
   input  wire cvn_lss_req_t  i_lss,
   input  wire cvn_nmt_t      i_nmt_state,
   input  wire logic          i_baud_detect,
   input  wire cvn_can_evt_t  i_can,
   output logic [6:0]         o_node_addr,
   output logic               o_addr_valid,
   output cvn_obj_rsp_t       o_obj,
   output logic               o_nv_wr,
   output logic [6:0]         o_nv_data,
   output logic               o_lss_cfg_mode,
   output cvn_bt_t            o_bt,
   output cvn_led_t           o_led
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [7:0]   sw_s1;
      logic [7:0]   sw_s2;
      logic         va_s1;
      logic         va_s2;
      logic [1:0]   init_cnt;
      logic         init_done;
      logic [6:0]   node_addr;
      logic [6:0]   stored_addr;
      logic         lss_cfg;
      cvn_bt_t      bt;
      logic         nv_wr;
      cvn_obj_rsp_t rsp;
      logic [23:0]  tick_cnt;
      logic         tick;
      logic [5:0]   ph;
      logic         flk;
      logic         pwr_up;
      logic         hb_f;
      logic         sync_f;
      cvn_led_t     led;
   } cvn_state_t;

   cvn_state_t st_r;
   cvn_state_t st_nxt;

   localparam logic [23:0] TICK_LAST = 24'(P_TICK_CYC - 1);

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a >= `CVN_ADDR_MIN) && (a <= `CVN_ADDR_MAX);
   endfunction : addr_ok

   function automatic logic flash_on(input logic [5:0] ph,
                                     input logic [5:0] n);
      flash_on = (ph < n * `CVN_FLASH_TICKS) && !ph[2];
   endfunction : flash_on

   logic [7:0] sw_addr;
   logic       sw_bcd_ok;
   logic       obj_addr_hit;
   logic       obj_valve_hit;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      // only the second stage is read by logic
      st_nxt.sw_s1 = {i_sel_tens, i_sel_ones};
      st_nxt.sw_s2 = st_r.sw_s1;
      st_nxt.va_s1 = i_valve_supply;
      st_nxt.va_s2 = st_r.va_s1;
      st_nxt.nv_wr = 1'b0;
      st_nxt.bt.bt_act = 1'b0;
      st_nxt.rsp.ack = 1'b0;
      st_nxt.rsp.err = 1'b0;

      sw_bcd_ok = (st_r.sw_s2[7:4] <= `CVN_BCD_MAX)
                  && (st_r.sw_s2[3:0] <= `CVN_BCD_MAX);
      sw_addr = 8'(st_r.sw_s2[7:4] * 8'h0A) + 8'(st_r.sw_s2[3:0]);

      // wait for the synchronisers to fill, then sample once
      if (!st_r.init_done) begin
         st_nxt.init_cnt = st_r.init_cnt + 2'h1;
         if (st_r.init_cnt == `CVN_INIT_LAST) begin
            st_nxt.init_done = 1'b1;
            if (addr_ok(i_nv_addr)) begin
               st_nxt.stored_addr = i_nv_addr[6:0];
            end
            if (sw_bcd_ok && sw_addr != 8'h00
                && sw_addr <= `CVN_SW_ADDR_MAX) begin
               st_nxt.node_addr = sw_addr[6:0];
            end else if (sw_addr == 8'h00 && addr_ok(i_nv_addr)) begin
               st_nxt.node_addr = i_nv_addr[6:0];
            end else begin
               st_nxt.node_addr = `CVN_ADDR_DEFAULT;
            end
         end
      end

      // object dictionary access, answered one cycle later
      obj_addr_hit = (i_obj.index == `CVN_IDX_NODE_ADDR)
                     && (i_obj.sub == `CVN_SUB_ZERO);
      obj_valve_hit = (i_obj.index == `CVN_IDX_VALVE_STAT)
                      && (i_obj.sub == `CVN_SUB_ZERO);
      if (i_obj_req) begin
         st_nxt.rsp.ack = 1'b1;
         st_nxt.rsp.rdata = 8'h00;
         if (obj_addr_hit && i_obj.wr) begin
            if (addr_ok(i_obj.wdata)) begin
               st_nxt.stored_addr = i_obj.wdata[6:0];
               st_nxt.nv_wr = 1'b1;
            end else begin
               st_nxt.rsp.err = 1'b1;
            end
         end else if (obj_addr_hit) begin
            st_nxt.rsp.rdata = {1'b0, st_r.stored_addr};
         end else if (obj_valve_hit && !i_obj.wr) begin
            st_nxt.rsp.rdata = st_r.va_s2 ? `CVN_VALVE_ON
                                          : `CVN_VALVE_OFF;
         end else begin
            st_nxt.rsp.err = 1'b1;
         end
      end

      // layer setting service; a new node id stays pending until reset
      if (i_lss_valid && i_lss_cob == `CVN_COB_LSS) begin
         unique case (i_lss.cs)
            `CVN_LSS_SWITCH: st_nxt.lss_cfg = i_lss.b1[0];
            `CVN_LSS_NODE_ID: begin
               if (st_r.lss_cfg && addr_ok(i_lss.b1)) begin
                  st_nxt.stored_addr = i_lss.b1[6:0];
               end
            end
            `CVN_LSS_BIT_SEL: begin
               if (st_r.lss_cfg) begin
                  st_nxt.bt.bt_sel = i_lss.b1;
                  st_nxt.bt.bt_idx = i_lss.b2;
               end
            end
            `CVN_LSS_BIT_ACT: begin
               st_nxt.bt.bt_act = 1'b1;
               st_nxt.bt.bt_delay = {i_lss.b2, i_lss.b1};
            end
            `CVN_LSS_STORE: st_nxt.nv_wr = st_r.lss_cfg;
            default: ;
         endcase
      end

      // indicator time base
      st_nxt.tick = 1'b0;
      if (st_r.tick_cnt == TICK_LAST) begin
         st_nxt.tick_cnt = 24'h000000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt + 24'h000001;
      end
      if (st_r.tick) begin
         st_nxt.flk = !st_r.flk;
         if (st_r.ph == `CVN_FRAME_LAST) begin
            st_nxt.ph = 6'h00;
            st_nxt.pwr_up = 1'b0;
         end else begin
            st_nxt.ph = st_r.ph + 6'h01;
         end
      end

      // sticky error events: a new event beats the clear
      st_nxt.hb_f = (st_r.hb_f && !i_can.clr)
                    || i_can.hb_evt || i_can.guard_evt;
      st_nxt.sync_f = (st_r.sync_f && !i_can.clr) || i_can.sync_evt;

      // indicators
      st_nxt.led.red = 1'b0;
      if (st_r.pwr_up) begin
         st_nxt.led.err = flash_on(st_r.ph, 6'h01);
         st_nxt.led.green = flash_on(st_r.ph, 6'h01);
         st_nxt.led.red = flash_on(st_r.ph, 6'h02)
                          && !flash_on(st_r.ph, 6'h01);
      end else if (i_baud_detect || st_r.lss_cfg) begin
         st_nxt.led.err = st_r.flk;
         st_nxt.led.green = !st_r.flk;
      end else begin
         unique case (i_nmt_state)
            CVN_NMT_PREOP: st_nxt.led.green = !st_r.ph[2];
            CVN_NMT_STOP:  st_nxt.led.green = flash_on(st_r.ph, 6'h01);
            CVN_NMT_OPER:  st_nxt.led.green = 1'b1;
            CVN_NMT_INIT:  st_nxt.led.green = 1'b0;
         endcase
         if (i_can.bus_off) begin
            st_nxt.led.err = 1'b1;
         end else if (st_r.sync_f) begin
            st_nxt.led.err = flash_on(st_r.ph, 6'h03);
         end else if (st_r.hb_f) begin
            st_nxt.led.err = flash_on(st_r.ph, 6'h02);
         end else if (i_can.warn) begin
            st_nxt.led.err = flash_on(st_r.ph, 6'h01);
         end else begin
            st_nxt.led.err = 1'b0;
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '0;
         st_r.node_addr <= `CVN_ADDR_DEFAULT;
         st_r.stored_addr <= `CVN_ADDR_DEFAULT;
         st_r.pwr_up <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_node_addr = st_r.node_addr;
   assign o_addr_valid = st_r.init_done;
   assign o_obj = st_r.rsp;
   assign o_nv_wr = st_r.nv_wr;
   assign o_nv_data = st_r.stored_addr;
   assign o_lss_cfg_mode = st_r.lss_cfg;
   assign o_bt = st_r.bt;
   assign o_led = st_r.led;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   a_addr_held_after: assert property (
      st_r.init_done |=> $stable(st_r.node_addr))
      else $error("active address changed after start-up");
   a_addr_in_range: assert property (
      st_r.init_done |-> (st_r.node_addr != 7'h00))
      else $error("active address zero");
   a_init_once: assert property (
      st_r.init_done |=> st_r.init_done)
      else $error("address sampling repeated");
   a_nv_write_ok: assert property (
      i_obj_req && i_obj.wr && obj_addr_hit && addr_ok(i_obj.wdata)
      |=> o_nv_wr && o_obj.ack && !o_obj.err
          && (o_nv_data == $past(i_obj.wdata[6:0])))
      else $error("valid address write not stored");
   a_nv_write_bad: assert property (
      i_obj_req && i_obj.wr && obj_addr_hit && !addr_ok(i_obj.wdata)
      |=> o_obj.err && !o_nv_wr && $stable(o_nv_data))
      else $error("bad address write not refused");
   a_valve_read: assert property (
      i_obj_req && !i_obj.wr && obj_valve_hit
      |=> o_obj.ack && (o_obj.rdata == {7'h00, $past(st_r.va_s2)}))
      else $error("valve status read wrong");
   a_bus_off_led: assert property (
      !st_r.pwr_up && !i_baud_detect && !st_r.lss_cfg && i_can.bus_off
      |=> o_led.err)
      else $error("bus off not shown steady");
   a_flicker_led: assert property (
      !st_r.pwr_up && i_baud_detect |=> (o_led.err != o_led.green))
      else $error("flicker pattern wrong");
   a_oper_green: assert property (
      !st_r.pwr_up && !i_baud_detect && !st_r.lss_cfg
      && i_nmt_state == CVN_NMT_OPER && !i_can.bus_off && !st_r.sync_f
      && !st_r.hb_f && !i_can.warn |=> o_led.green && !o_led.err)
      else $error("operational indication wrong");
   a_sync_set_wins: assert property (
      i_can.sync_evt |=> st_r.sync_f)
      else $error("sync event lost");
endmodule : cvn_node_cfg

// file: verif/cvn_master_model.sv
// master tool and nv memory model facing the node block
module cvn_master_model
   import cvn_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire cvn_obj_rsp_t i_rsp,
   input  wire logic         i_nv_wr,
   input  wire logic [6:0]   i_nv_data,
   output cvn_obj_req_t      o_obj,
   output logic              o_obj_req,
   output logic              o_lss_valid,
   output logic [10:0]       o_lss_cob,
   output cvn_lss_req_t      o_lss,
   output logic [7:0]        o_nv_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // nv memory and request drivers
   // ****
   logic [6:0] mem_r = 7'h00;
   assign o_nv_addr = {1'b0, mem_r};
   always @(posedge i_sys_clk) if (i_nv_wr) mem_r <= i_nv_data;
   initial begin
      o_obj_req   = 1'b0;
      o_obj       = '0;
      o_lss_valid = 1'b0;
      o_lss_cob   = 11'h000;
      o_lss       = '0;
   end
   task automatic obj_xfer(input logic wr, input logic [15:0] idx,
      input logic [7:0] sb, wd, output cvn_obj_rsp_t rsp);
      int n;
      @(posedge i_sys_clk);
      o_obj_req <= 1'b1;
      o_obj     <= '{wr, idx, sb, wd};
      @(posedge i_sys_clk);
      o_obj_req <= 1'b0;
      o_obj     <= ~o_obj; // released bytes flip, never look stale
      n = 0;
      #1;
      while (!(i_rsp.ack || i_rsp.err) && n < 4) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      rsp = i_rsp;
   endtask : obj_xfer
   task automatic lss_send(input logic [10:0] cob,
      input logic [7:0] cs, b1, b2);
      @(posedge i_sys_clk);
      o_lss_valid <= 1'b1;
      o_lss_cob   <= cob;
      o_lss       <= '{cs, b1, b2};
      @(posedge i_sys_clk);
      o_lss_valid <= 1'b0;
      o_lss       <= ~o_lss;
      #1;
   endtask : lss_send
endmodule : cvn_master_model

// file: verif/cvn_node_cfg_bench.sv
// self-checking bench for the node configuration block
`include "cvn_cfg.svh"
module cvn_node_cfg_bench
   import cvn_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // stimulus and checks
   // ****
   localparam int TICK = 4; // short tick keeps frames at 192 cycles
   localparam logic [15:0] NA = `CVN_IDX_NODE_ADDR;
   localparam logic [15:0] VS = `CVN_IDX_VALVE_STAT;
   localparam logic [10:0] LC = `CVN_COB_LSS;
   logic         clk, arst_n, valve, baud, obj_req, lss_valid;
   logic         addr_valid, nv_wr, cfg_mode;
   logic [3:0]   tens, ones;
   logic [7:0]   nv_addr;
   logic [10:0]  lss_cob;
   logic [6:0]   node_addr, nv_data;
   cvn_obj_req_t obj;
   cvn_obj_rsp_t rsp, r;
   cvn_lss_req_t lss;
   cvn_nmt_t     nmt;
   cvn_can_evt_t can;
   cvn_bt_t      bt;
   cvn_led_t     led;
   int           miscompares = 0;
   int           tests_run = 0;
   cvn_nmt_t     st[3] = '{CVN_NMT_PREOP, CVN_NMT_STOP, CVN_NMT_OPER};
   int           gn[3] = '{96, 16, 192};
   logic [5:0]   fc[3] = '{6'h08, 6'h04, 6'h20};
   int           fe[3] = '{32, 32, 16};

   cvn_node_cfg #(.P_TICK_CYC(TICK)) i_cvn_node_cfg (
      .i_sys_clk(clk), .i_arst_n(arst_n), .i_sel_tens(tens),
      .i_sel_ones(ones), .i_valve_supply(valve), .i_nv_addr(nv_addr),
      .i_obj_req(obj_req), .i_obj(obj), .i_lss_valid(lss_valid),
      .i_lss_cob(lss_cob), .i_lss(lss), .i_nmt_state(nmt),
      .i_baud_detect(baud), .i_can(can), .o_node_addr(node_addr),
      .o_addr_valid(addr_valid), .o_obj(rsp), .o_nv_wr(nv_wr),
      .o_nv_data(nv_data), .o_lss_cfg_mode(cfg_mode), .o_bt(bt),
      .o_led(led));
   cvn_master_model i_cvn_master_model (
      .i_sys_clk(clk), .i_rsp(rsp), .i_nv_wr(nv_wr), .i_nv_data(nv_data),
      .o_obj(obj), .o_obj_req(obj_req), .o_lss_valid(lss_valid),
      .o_lss_cob(lss_cob), .o_lss(lss), .o_nv_addr(nv_addr));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
                  exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task automatic do_reset(input logic [3:0] t, o, input logic [6:0] e);
      int n;
      @(posedge clk);
      arst_n <= 1'b0;
      tens   <= t;
      ones   <= o;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      n = 0;
      #1;
      while (addr_valid !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({9'h0, node_addr}, {9'h0, e});
   endtask : do_reset
   task automatic ev(input logic [5:0] v); // levels stay, pulses drop
      @(posedge clk);
      can <= v;
      @(posedge clk);
      can <= {v[5:4], 4'h0};
      repeat (2) @(posedge clk);
   endtask : ev
   task automatic led_frame(input int ee, eg, ed); // one 48-tick frame
      int ne, ng, nd;
      ne = 0;
      ng = 0;
      nd = 0;
      repeat (48 * TICK) begin
         @(posedge clk);
         #1;
         ne += int'(led.err === 1'b1);
         ng += int'(led.green === 1'b1);
         nd += int'(led.err !== led.green);
      end
      chk(16'(ne), 16'(ee));
      chk(16'(ng), 16'(eg));
      chk(16'(nd), 16'(ed));
   endtask : led_frame
   task automatic oc(input logic wr, input logic [15:0] idx,
      input logic [7:0] sb, wd, input logic [2:0] ef, input logic [7:0] ed);
      i_cvn_master_model.obj_xfer(wr, idx, sb, wd, r);
      chk({13'h0, r.ack, r.err, nv_wr}, {13'h0, ef});
      chk({8'h0, wr ? {1'b0, nv_data} : r.rdata}, {8'h0, ed});
   endtask : oc
   task automatic ls(input logic [10:0] cb, input logic [7:0] c, x, y);
      i_cvn_master_model.lss_send(cb, c, x, y);
   endtask : ls

   initial begin
      repeat (12000) @(posedge clk);
      miscompares++;
      finish_test();
   end
   initial begin
      arst_n = 1'b0;
      tens   = 4'h0;
      ones   = 4'h0;
      valve  = 1'b1;
      baud   = 1'b0;
      nmt    = CVN_NMT_INIT;
      can    = '0;
      do_reset(4'h0, 4'h0, `CVN_ADDR_DEFAULT);
      repeat (4) @(posedge clk);
      #1;
      chk({13'h0, led}, 16'h0006);
      repeat (32) @(posedge clk);
      #1;
      chk({13'h0, led}, 16'h0001);
      repeat (160) @(posedge clk);
      foreach (st[i]) begin
         nmt <= st[i];
         repeat (2) @(posedge clk);
         led_frame(0, gn[i], gn[i]);
         @(posedge clk);
      end
      ev(6'h12);
      led_frame(192, 192, 0);
      ev(6'h00);
      led_frame(48, 192, 144);
      foreach (fc[i]) begin
         ev(6'h01);
         ev(fc[i]);
         led_frame(fe[i], 192, 192 - fe[i]);
      end
      ev(6'h01);
      baud <= 1'b1;
      repeat (2) @(posedge clk);
      led_frame(96, 96, 192);
      @(posedge clk);
      baud <= 1'b0;
      do_reset(4'h9, 4'h9, 7'h63);
      @(posedge clk);
      tens <= 4'h1;
      ones <= 4'h2;
      repeat (8) @(posedge clk);
      #1;
      chk({9'h0, node_addr}, 16'h0063);
      oc(1'b1, NA, 8'h00, 8'h05, 3'b101, 8'h05);
      oc(1'b1, NA, 8'h00, 8'h00, 3'b110, 8'h05);
      oc(1'b1, NA, 8'h00, 8'h80, 3'b110, 8'h05);
      oc(1'b1, NA, 8'h01, 8'h07, 3'b110, 8'h05);
      oc(1'b1, NA, 8'h00, 8'h7F, 3'b101, 8'h7F);
      oc(1'b0, NA, 8'h00, 8'h00, 3'b100, 8'h7F);
      oc(1'b0, VS, 8'h00, 8'h00, 3'b100, 8'h01);
      oc(1'b1, VS, 8'h00, 8'h01, 3'b110, 8'h7F);
      @(posedge clk);
      valve <= 1'b0;
      repeat (4) @(posedge clk);
      oc(1'b0, VS, 8'h00, 8'h00, 3'b100, 8'h00);
      ls(LC, `CVN_LSS_SWITCH, 8'h01, 8'h00);
      chk({15'h0, cfg_mode}, 16'h0001);
      ls(LC, `CVN_LSS_NODE_ID, 8'h14, 8'h00);
      chk({9'h0, nv_data}, 16'h0014);
      ls(LC, `CVN_LSS_NODE_ID, 8'h80, 8'h00);
      chk({9'h0, nv_data}, 16'h0014);
      ls(LC, `CVN_LSS_STORE, 8'h00, 8'h00);
      chk({15'h0, nv_wr}, 16'h0001);
      ls(LC, `CVN_LSS_BIT_SEL, 8'h02, 8'h05);
      chk({bt.bt_sel, bt.bt_idx}, 16'h0205);
      ls(LC, `CVN_LSS_BIT_ACT, 8'h34, 8'h12);
      chk({15'h0, bt.bt_act}, 16'h0001);
      chk(bt.bt_delay, 16'h1234);
      ls(11'h7E4, `CVN_LSS_SWITCH, 8'h00, 8'h00);
      chk({15'h0, cfg_mode}, 16'h0001);
      repeat (200) @(posedge clk);
      led_frame(96, 96, 192);
      ls(LC, `CVN_LSS_SWITCH, 8'h00, 8'h00);
      ls(LC, `CVN_LSS_NODE_ID, 8'h22, 8'h00);
      chk({9'h0, nv_data}, 16'h0014);
      do_reset(4'h0, 4'h0, 7'h14);
      finish_test();
   end
endmodule : cvn_node_cfg_bench
